// File: fsps_pkg.sv
// Constants for the float mode pulse sequencer: register offsets,
// field positions, reset values, timing counts and the state encoding.
// Assumes a single 125 MHz clock and a 16-bit internal register port.
package fsps_pkg;

    // Clock and time units
    localparam int CLK_PERIOD_PS = 8000;
    localparam int US_PS = 1000000;
    localparam int STEP_PS = 31250;
    localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;

    // Register offsets
    localparam logic [7:0] OFF_SRC_SEL = 8'h14;
    localparam logic [7:0] OFF_A_PULSE = 8'h30;
    localparam logic [7:0] OFF_A_CNTPER = 8'h31;
    localparam logic [7:0] OFF_B_PULSE = 8'h35;
    localparam logic [7:0] OFF_B_CNTPER = 8'h36;
    localparam logic [7:0] OFF_PER_HI = 8'h37;
    localparam logic [7:0] OFF_A_INTEG = 8'h39;
    localparam logic [7:0] OFF_B_INTEG = 8'h3b;
    localparam logic [7:0] OFF_A_LEDSEL = 8'h3e;
    localparam logic [7:0] OFF_B_LEDSEL = 8'h3f;
    localparam logic [7:0] OFF_A_AMPREF = 8'h42;
    localparam logic [7:0] OFF_A_FECFG = 8'h43;
    localparam logic [7:0] OFF_B_AMPREF = 8'h44;
    localparam logic [7:0] OFF_B_FECFG = 8'h45;
    localparam logic [7:0] OFF_CATHODE = 8'h54;
    localparam logic [7:0] OFF_MATH = 8'h58;
    localparam logic [7:0] OFF_B_FLTCTL = 8'h59;
    localparam logic [7:0] OFF_FIRE = 8'h5a;
    localparam logic [7:0] OFF_A_FLTCTL = 8'h5e;
    localparam logic [7:0] OFF_STATUS = 8'h7f;

    // Storage indices
    localparam int NUM_REGS = 19;
    localparam logic [4:0] IDX_NONE = 5'h1f;

    // Reset value of every configuration word
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Field positions (low bit), slot A then slot B
    localparam int SRC_A_LSB = 0;
    localparam int SRC_B_LSB = 2;
    localparam int FLOAT_EN_LSB = 13;
    localparam int PRECON_LSB = 8;
    localparam int CONN_LSB = 8;
    localparam int DUMP_OFF_LSB = 0;
    localparam int PER_LO_LSB = 0;
    localparam int COUNT_LSB = 8;
    localparam int PER_HI_A_LSB = 0;
    localparam int PER_HI_B_LSB = 8;
    localparam int INT_W_LSB = 11;
    localparam int INT_OFF_LSB = 0;
    localparam int LED_CHOICE_LSB = 14;
    localparam int MATH12_A_LSB = 1;
    localparam int MATH12_B_LSB = 5;
    localparam int MATH34_A_LSB = 8;
    localparam int MATH34_B_LSB = 10;
    localparam int CATH_OVR_BIT = 7;
    localparam int CATH_A_LSB = 8;
    localparam int CATH_B_LSB = 10;
    localparam int FIRE_A_LSB = 8;
    localparam int FIRE_B_LSB = 12;

    // Field codes
    localparam logic [1:0] SRC_FLOAT = 2'h0;
    localparam logic [1:0] FLOAT_EN_ON = 2'h3;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_WRITE = 2'b11
    } fsps_state_t;

endpackage

// File: fsps_sequencer.sv
// Float mode pulse sequencer: register store, per-pulse phase timing,
// LED fire and add/subtract control, and the per-period result write.
// Assumes the timebase, ADC and register port all run on CLK.
//
// Overview of operation
// - A slot runs float mode only when its light source select field is zero.
// - Float enable code 3 lets the photodiode float between connect pulses.
// - Pulse-one-two math code 2 subtracts pulse one and adds pulse two.
// - Pulse-three-four math code 1 adds pulse three and subtracts pulse four.
// - Override bit set takes cathode bias from per-slot fields, ignoring default.
// - Precondition time up to first float comes from five-bit field.
// - Ten-bit float period in microseconds, low eight bits, is the second float time.
// - Upper two float period bits come from the shared high-bits register.
// - Photodiode stays connected for the connect width to dump its charge.
// - First float time is dump offset plus connect width minus precondition.
// - Integrator starts at eleven-bit offset counted in 31.25 ns steps.
// - Pulse count field sets pulses per sample period; two for ambient.
// - Float LED mode uses equal pulses in pairs, LED firing once per pair.
// - With that grouping pulses two, three add and pulses one, four subtract.
// - LED fires only in pulse positions enabled in the fire pattern field.
// - Add or subtract per position comes from the two math fields.
// - The four-pulse fire and math pattern repeats through all pulses.
// - One final accumulated write per sample period, not one per group.
// - Float LED choice: 00 none, 01 first, 10 second, 11 third LED.
module fsps_sequencer (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    // Slot timebase
    input wire logic SLOT_START,
    input wire logic SLOT_IS_B,
    // Cathode setting held elsewhere in the device
    input wire logic [1:0] CATHODE_DEFAULT,
    // Analog controls
    output logic PD_CONNECT,
    output logic PD_FLOAT,
    output logic INTEG_ON,
    output logic [2:0] LED_DRIVE,
    output logic [1:0] CATHODE_SEL,
    // ADC handshake
    output logic ADC_START,
    input wire logic ADC_DONE,
    input wire logic [13:0] ADC_RESULT,
    // Result write
    output logic DATA_WR,
    output logic DATA_SLOT,
    output logic [19:0] DATA_OUT,
    output logic BUSY
);

    // Map an offset to a storage slot; unmapped gives IDX_NONE
    function automatic logic [4:0] reg_index(input logic [7:0] addr);
        unique case (addr)
            fsps_pkg::OFF_SRC_SEL: reg_index = 5'h00;
            fsps_pkg::OFF_A_PULSE: reg_index = 5'h01;
            fsps_pkg::OFF_A_CNTPER: reg_index = 5'h02;
            fsps_pkg::OFF_B_PULSE: reg_index = 5'h03;
            fsps_pkg::OFF_B_CNTPER: reg_index = 5'h04;
            fsps_pkg::OFF_PER_HI: reg_index = 5'h05;
            fsps_pkg::OFF_A_INTEG: reg_index = 5'h06;
            fsps_pkg::OFF_B_INTEG: reg_index = 5'h07;
            fsps_pkg::OFF_A_LEDSEL: reg_index = 5'h08;
            fsps_pkg::OFF_B_LEDSEL: reg_index = 5'h09;
            fsps_pkg::OFF_A_AMPREF: reg_index = 5'h0a;
            fsps_pkg::OFF_A_FECFG: reg_index = 5'h0b;
            fsps_pkg::OFF_B_AMPREF: reg_index = 5'h0c;
            fsps_pkg::OFF_B_FECFG: reg_index = 5'h0d;
            fsps_pkg::OFF_CATHODE: reg_index = 5'h0e;
            fsps_pkg::OFF_MATH: reg_index = 5'h0f;
            fsps_pkg::OFF_B_FLTCTL: reg_index = 5'h10;
            fsps_pkg::OFF_FIRE: reg_index = 5'h11;
            fsps_pkg::OFF_A_FLTCTL: reg_index = 5'h12;
            default: reg_index = fsps_pkg::IDX_NONE;
        endcase
    endfunction

    // Microseconds to clock cycles
    function automatic logic signed [22:0] us_to_cyc(input logic [9:0] us);
        us_to_cyc = 23'(us) * 23'(fsps_pkg::CYC_PER_US);
    endfunction

    // One word per mapped offset
    logic [15:0] cfg_reg [fsps_pkg::NUM_REGS];
    logic [15:0] rdata_reg;
    // Sequencer state and pulse counters
    fsps_pkg::fsps_state_t state_reg;
    logic slot_b_reg;
    logic [7:0] pulse_idx_reg;
    logic signed [22:0] t_reg;
    logic signed [19:0] acc_reg;
    // Registered copies of the outputs
    logic pd_connect_reg, pd_float_reg, integ_reg, adc_start_reg;
    logic data_wr_reg, data_slot_reg, busy_reg;
    logic [2:0] led_reg;
    logic [1:0] cath_reg;
    logic [19:0] data_out_reg;

    // Per-slot field views; slot B never reads slot A fields
    logic [15:0] w_pulse, w_cntper, w_integ, w_ledsel, w_fltctl, w_math, w_fire, w_per_hi, w_cath, w_src;
    logic [1:0] src_sel, float_en, math12, math34, led_choice, cath_slot;
    logic [4:0] precon_us, conn_us, int_w_us;
    logic [7:0] dump_off_us, pulse_count;
    logic [9:0] period_us;
    logic [10:0] int_off_steps;
    logic [3:0] fire_pat;
    always_comb begin
        w_src = cfg_reg[0];
        w_per_hi = cfg_reg[5];
        w_cath = cfg_reg[14];
        w_math = cfg_reg[15];
        w_fire = cfg_reg[17];
        w_pulse = slot_b_reg ? cfg_reg[3] : cfg_reg[1];
        w_cntper = slot_b_reg ? cfg_reg[4] : cfg_reg[2];
        w_integ = slot_b_reg ? cfg_reg[7] : cfg_reg[6];
        w_ledsel = slot_b_reg ? cfg_reg[9] : cfg_reg[8];
        w_fltctl = slot_b_reg ? cfg_reg[16] : cfg_reg[18];
        src_sel = SLOT_IS_B ? w_src[fsps_pkg::SRC_B_LSB +: 2] : w_src[fsps_pkg::SRC_A_LSB +: 2];
        float_en = w_fltctl[fsps_pkg::FLOAT_EN_LSB +: 2];
        precon_us = w_fltctl[fsps_pkg::PRECON_LSB +: 5];
        conn_us = w_pulse[fsps_pkg::CONN_LSB +: 5];
        dump_off_us = w_pulse[fsps_pkg::DUMP_OFF_LSB +: 8];
        period_us = {slot_b_reg ? w_per_hi[fsps_pkg::PER_HI_B_LSB +: 2]
                                : w_per_hi[fsps_pkg::PER_HI_A_LSB +: 2],
                     w_cntper[fsps_pkg::PER_LO_LSB +: 8]};
        pulse_count = w_cntper[fsps_pkg::COUNT_LSB +: 8];
        int_w_us = w_integ[fsps_pkg::INT_W_LSB +: 5];
        int_off_steps = w_integ[fsps_pkg::INT_OFF_LSB +: 11];
        led_choice = w_ledsel[fsps_pkg::LED_CHOICE_LSB +: 2];
        math12 = slot_b_reg ? w_math[fsps_pkg::MATH12_B_LSB +: 2] : w_math[fsps_pkg::MATH12_A_LSB +: 2];
        math34 = slot_b_reg ? w_math[fsps_pkg::MATH34_B_LSB +: 2] : w_math[fsps_pkg::MATH34_A_LSB +: 2];
        fire_pat = slot_b_reg ? w_fire[fsps_pkg::FIRE_B_LSB +: 4] : w_fire[fsps_pkg::FIRE_A_LSB +: 4];
        cath_slot = slot_b_reg ? w_cath[fsps_pkg::CATH_B_LSB +: 2] : w_cath[fsps_pkg::CATH_A_LSB +: 2];
    end

    // Phase boundaries in cycles from pulse start
    logic first_pulse;
    logic signed [22:0] float1_us, float_cyc, precon_end, float_end, conn_end, integ_start, integ_end, pulse_end;
    always_comb begin
        first_pulse = (pulse_idx_reg == 8'h00);
        float1_us = 23'(dump_off_us) + 23'(conn_us) - 23'(precon_us);
        if (float1_us < 0) begin
            float1_us = '0; // Misprogrammed offset gives no float rather than a wrap
        end
        float_cyc = first_pulse ? float1_us * 23'(fsps_pkg::CYC_PER_US) : us_to_cyc(period_us);
        // Each phase edge builds on the last
        precon_end = us_to_cyc(10'(precon_us));
        float_end = precon_end + float_cyc;
        conn_end = float_end + us_to_cyc(10'(conn_us));
        // Later pulses dump later by float2 - float1; the integrator follows
        integ_start = 23'((32'(int_off_steps) * fsps_pkg::STEP_PS) / fsps_pkg::CLK_PERIOD_PS);
        if (!first_pulse) begin
            integ_start = integ_start + float_cyc - float1_us * 23'(fsps_pkg::CYC_PER_US);
        end
        integ_end = integ_start + us_to_cyc(10'(int_w_us));
        // Ends once dump and integrator are done
        pulse_end = (integ_end > conn_end) ? integ_end : conn_end;
    end

    // Position within the repeating four-pulse group
    logic [1:0] pos;
    logic fire_now, subtract_now;
    always_comb begin
        pos = pulse_idx_reg[1:0];
        // Pattern bit n covers group position n
        fire_now = fire_pat[pos];
        // High bit of each math field is the earlier pulse; 1 means subtract
        unique case (pos)
            2'd0: subtract_now = math12[1];
            2'd1: subtract_now = math12[0];
            2'd2: subtract_now = math34[1];
            default: subtract_now = math34[0];
        endcase
    end

    // Register writes; configuration is live, so change it between slots
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < fsps_pkg::NUM_REGS; i++) begin
                cfg_reg[i] <= fsps_pkg::CFG_RESET;
            end
        end else if (REG_WR && reg_index(REG_ADDR) != fsps_pkg::IDX_NONE) begin
            cfg_reg[reg_index(REG_ADDR)] <= REG_WDATA;
        end
    end

    // Register reads, status word shows the sequencer state
    // Unmapped offsets read zero, harmless to probe
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
        end else if (REG_RD) begin
            if (REG_ADDR == fsps_pkg::OFF_STATUS) begin
                rdata_reg <= {pulse_idx_reg, 3'b000, slot_b_reg, 2'(state_reg), 1'b0, busy_reg};
            end else if (reg_index(REG_ADDR) == fsps_pkg::IDX_NONE) begin
                rdata_reg <= 16'h0000;
            end else begin
                rdata_reg <= cfg_reg[reg_index(REG_ADDR)];
            end
        end
    end

    // Sequencer: pulse timing, ADC handshake, final write
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= fsps_pkg::ST_IDLE;
            slot_b_reg <= 1'b0;
            pulse_idx_reg <= 8'h00;
            t_reg <= '0;
            acc_reg <= '0;
            adc_start_reg <= 1'b0;
            data_wr_reg <= 1'b0;
            data_slot_reg <= 1'b0;
            data_out_reg <= 20'h0_0000;
        end else begin
            adc_start_reg <= 1'b0;
            data_wr_reg <= 1'b0;
            unique case (state_reg)
                fsps_pkg::ST_IDLE: begin
                    // Slots in other source modes are left to other logic
                    if (SLOT_START && src_sel == fsps_pkg::SRC_FLOAT) begin
                        slot_b_reg <= SLOT_IS_B;
                        pulse_idx_reg <= 8'h00;
                        t_reg <= '0;
                        acc_reg <= '0;
                        state_reg <= fsps_pkg::ST_RUN;
                    end
                end
                fsps_pkg::ST_RUN: begin
                    // Zero count still writes one result
                    if (pulse_count == 8'h00) begin
                        state_reg <= fsps_pkg::ST_WRITE;
                    end else if (t_reg >= pulse_end - 1) begin
                        adc_start_reg <= 1'b1;
                        state_reg <= fsps_pkg::ST_SAMPLE;
                    end else begin
                        t_reg <= t_reg + 23'sd1;
                    end
                end
                fsps_pkg::ST_SAMPLE: begin
                    // Result bus only valid with done
                    if (ADC_DONE) begin
                        if (subtract_now) begin
                            acc_reg <= acc_reg - 20'(ADC_RESULT);
                        end else begin
                            acc_reg <= acc_reg + 20'(ADC_RESULT);
                        end
                        t_reg <= '0;
                        pulse_idx_reg <= pulse_idx_reg + 8'h01;
                        // Last pulse closes the period
                        if (pulse_idx_reg + 8'h01 >= pulse_count) begin
                            state_reg <= fsps_pkg::ST_WRITE;
                        end else begin
                            state_reg <= fsps_pkg::ST_RUN;
                        end
                    end
                end
                fsps_pkg::ST_WRITE: begin
                    data_wr_reg <= 1'b1;
                    data_slot_reg <= slot_b_reg;
                    data_out_reg <= acc_reg;
                    state_reg <= fsps_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Analog switch controls, one cycle behind the phase counter
    logic in_run, in_float, in_conn;
    always_comb begin
        in_run = (state_reg == fsps_pkg::ST_RUN);
        in_float = in_run && t_reg >= precon_end && t_reg < float_end;
        in_conn = in_run && t_reg >= float_end && t_reg < conn_end;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pd_connect_reg <= 1'b0;
            pd_float_reg <= 1'b0;
            integ_reg <= 1'b0;
            led_reg <= 3'b000;
            busy_reg <= 1'b0;
        end else begin
            // Without float enable the diode stays on the amplifier
            pd_float_reg <= in_float && float_en == fsps_pkg::FLOAT_EN_ON;
            pd_connect_reg <= in_run && t_reg < conn_end
                              && !(in_float && float_en == fsps_pkg::FLOAT_EN_ON);
            integ_reg <= in_run && t_reg >= integ_start && t_reg < integ_end;
            if (in_float && fire_now) begin
                unique case (led_choice)
                    2'b00: led_reg <= 3'b000;
                    2'b01: led_reg <= 3'b001;
                    2'b10: led_reg <= 3'b010;
                    default: led_reg <= 3'b100;
                endcase
            end else begin
                led_reg <= 3'b000;
            end
            // Busy trails the state by a cycle
            busy_reg <= (state_reg != fsps_pkg::ST_IDLE);
            if (in_conn && t_reg == float_end) begin
                led_reg <= 3'b000; // LED never overlaps the dump
            end
        end
    end

    // Cathode bias source
    // Default is held outside this block
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cath_reg <= 2'b00;
        end else if (w_cath[fsps_pkg::CATH_OVR_BIT]) begin
            cath_reg <= cath_slot;
        end else begin
            cath_reg <= CATHODE_DEFAULT;
        end
    end

    // Outputs
    // Each one a plain register copy
    assign REG_RDATA = rdata_reg;
    assign PD_CONNECT = pd_connect_reg;
    assign PD_FLOAT = pd_float_reg;
    assign INTEG_ON = integ_reg;
    assign LED_DRIVE = led_reg;
    assign CATHODE_SEL = cath_reg;
    assign ADC_START = adc_start_reg;
    assign DATA_WR = data_wr_reg;
    assign DATA_SLOT = data_slot_reg;
    assign DATA_OUT = data_out_reg;
    assign BUSY = busy_reg;

endmodule

// File: fsps_sequencer_assertions.sv
// Port-level checker for the float mode pulse sequencer.
// Assumes it is bound to fsps_sequencer and sees only its ports.
module fsps_seq_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Observed ports
    input wire logic SLOT_START,
    input wire logic BUSY,
    input wire logic ADC_START,
    input wire logic ADC_DONE,
    input wire logic DATA_WR,
    input wire logic [19:0] DATA_OUT,
    input wire logic PD_CONNECT,
    input wire logic PD_FLOAT,
    input wire logic [2:0] LED_DRIVE
);
    // One clock domain; nothing is judged while reset is low
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Strobes are single-cycle and framed by the busy window
    wr_pulse_a: assert property (DATA_WR |=> !DATA_WR) else $error("result strobe too long");
    adc_pulse_a: assert property (ADC_START |=> !ADC_START) else $error("sample request too long");
    adc_in_period_a: assert property (ADC_START |-> BUSY) else $error("sample request while idle");
    write_ends_period_a: assert property (DATA_WR |-> ##[1:2] !BUSY) else $error("busy outlives write");
    // Busy only follows an accepted start two cycles earlier
    busy_after_start_a: assert property ($rose(BUSY) |-> $past(SLOT_START, 2)) else $error("busy without start");
    // Result word only moves with its strobe, so one write per period shows
    result_holds_a: assert property (!DATA_WR |-> $stable(DATA_OUT)) else $error("result moved silently");
    // Diode is never both floating and on the amplifier
    float_excl_a: assert property (!(PD_CONNECT && PD_FLOAT)) else $error("float and connect together");
    float_in_period_a: assert property (PD_FLOAT |-> BUSY) else $error("float outside period");
    // At most one LED, and only inside a period
    led_one_hot_a: assert property ($onehot0(LED_DRIVE)) else $error("several LEDs driven");
    led_in_period_a: assert property (|LED_DRIVE |-> BUSY) else $error("LED fired while idle");

    // Main scenarios reached
    result_c: cover property (DATA_WR);
    sample_c: cover property (ADC_START ##[1:8] ADC_DONE);
    led_fire_c: cover property (|LED_DRIVE ##1 PD_FLOAT);
endmodule

bind fsps_sequencer fsps_seq_checker fsps_seq_checker_i (.CLK, .RST_N, .SLOT_START, .BUSY, .ADC_START,
    .ADC_DONE, .DATA_WR, .DATA_OUT, .PD_CONNECT, .PD_FLOAT, .LED_DRIVE);

// File: fsps_analog_model.sv
// Far-side model: an ADC answering each sample request after a set delay,
// plus probes of float time, LED drive per pulse and cathode code.
// Assumes the sequencer's clock; results are a fixed ramp per pulse.
module fsps_analog_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sequencer side
    input wire logic slot_start,
    input wire logic busy,
    input wire logic adc_start,
    input wire logic pd_float,
    input wire logic integ_on,
    input wire logic [2:0] led_drive,
    input wire logic [1:0] cathode_sel,
    input wire logic [3:0] adc_delay,
    output logic adc_done,
    output logic [13:0] adc_result
);
    logic [3:0] wait_cnt;
    logic [7:0] pulse_idx;
    logic [1:0] cath_seen;
    logic [2:0] led_seen [0:7];
    int float_cnt, integ_cnt;

    // Conversion; the result line toggles when not valid so stale data shows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            adc_done <= 1'b0;
            adc_result <= 14'h0000;
        end else begin
            adc_done <= (wait_cnt == 4'h1);
            adc_result <= (wait_cnt == 4'h1) ? 14'h0040 + 14'(pulse_idx) * 14'h0101 : ~adc_result;
            if (adc_start) wait_cnt <= adc_delay;
            else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
        end
    end

    // Per-period probes but cath_seen, cleared by any start seen while busy is low
    always_ff @(posedge clk) begin
        if (!rst_n || (slot_start && !busy)) begin
            pulse_idx <= 8'h00;
            float_cnt <= 0;
            integ_cnt <= 0;
            foreach (led_seen[i]) led_seen[i] <= 3'h0;
        end else begin
            if (pd_float) float_cnt <= float_cnt + 1;
            if (integ_on) integ_cnt <= integ_cnt + 1;
            if (adc_done) pulse_idx <= pulse_idx + 8'h01;
            if (adc_start) cath_seen <= cathode_sel;
            led_seen[pulse_idx[2:0]] <= led_seen[pulse_idx[2:0]] | led_drive;
        end
    end
endmodule

// File: fsps_sequencer_tb.sv
// Bench for the float mode pulse sequencer: register access, a refused
// start and two slot runs checked against values worked out from the fields.
// Assumes the analog model answers sample requests and records probes.
module fsps_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [15:0] REG_WDATA = 16'h0000;
    logic SLOT_START = 1'b0;
    logic SLOT_IS_B = 1'b0;
    logic [1:0] CATHODE_DEFAULT = 2'h1;
    logic [3:0] adc_delay = 4'h1;
    logic [15:0] REG_RDATA;
    logic [13:0] ADC_RESULT;
    logic [19:0] DATA_OUT;
    logic [2:0] LED_DRIVE;
    logic [1:0] CATHODE_SEL;
    logic PD_CONNECT, PD_FLOAT, INTEG_ON, ADC_START, ADC_DONE, DATA_WR, DATA_SLOT, BUSY;
    int error_cnt = 0;
    int num_checks = 0;

    fsps_sequencer fsps_sequencer_i (.CLK, .RST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA,
        .SLOT_START, .SLOT_IS_B, .CATHODE_DEFAULT, .PD_CONNECT, .PD_FLOAT, .INTEG_ON, .LED_DRIVE,
        .CATHODE_SEL, .ADC_START, .ADC_DONE, .ADC_RESULT, .DATA_WR, .DATA_SLOT, .DATA_OUT, .BUSY);
    fsps_analog_model fsps_analog_model_i (.clk(CLK), .rst_n(RST_N), .slot_start(SLOT_START), .busy(BUSY),
        .adc_start(ADC_START), .pd_float(PD_FLOAT), .led_drive(LED_DRIVE), .cathode_sel(CATHODE_SEL),
        .integ_on(INTEG_ON), .adc_delay(adc_delay), .adc_done(ADC_DONE), .adc_result(ADC_RESULT));

    // 125 MHz clock
    initial begin
        forever #4 CLK = ~CLK;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Register port: one-cycle strobes, read data one cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK) #1;
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(posedge CLK) #1;
        REG_WR = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge CLK) #1;
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(posedge CLK) #1;
        REG_RD = 1'b0;
        chk($sformatf("register %h", a), {16'h0000, exp}, {16'h0000, REG_RDATA});
    endtask

    // Start a period, restart it once while busy, count writes until idle
    task automatic run(input logic slot_b, input int limit, output int writes);
        int n;
        writes = 0;
        @(posedge CLK) #1;
        SLOT_START = 1'b1;
        SLOT_IS_B = slot_b;
        for (n = 0; n < limit && !(writes > 0 && BUSY === 1'b0); n++) begin
            @(posedge CLK) #1;
            SLOT_START = (n == 20);
            #1;
            if (DATA_WR === 1'b1) writes++;
        end
        if (n >= limit) begin
            error_cnt++;
            $display("unexpected timeout: expected result write, seen none");
            end_sim();
        end
    endtask

    // Signed sum of the model's ramp; sub bit p marks pulse position p
    function automatic logic [19:0] exp_sum(input int cnt, input logic [3:0] sub);
        logic [19:0] s;
        s = 20'h0_0000;
        for (int i = 0; i < cnt; i++) begin
            if (sub[i % 4]) s = s - 20'(14'h0040 + 14'(i) * 14'h0101);
            else s = s + 20'(14'h0040 + 14'(i) * 14'h0101);
        end
        return s;
    endfunction

    initial begin
        int w;
        repeat (6) @(posedge CLK);
        #1 RST_N = 1'b1;
        rd(fsps_pkg::OFF_A_PULSE, fsps_pkg::CFG_RESET);
        rd(fsps_pkg::OFF_MATH, fsps_pkg::CFG_RESET);
        wr(8'h20, 16'hffff);
        rd(8'h20, 16'h0000);
        wr(fsps_pkg::OFF_STATUS, 16'hffff);
        rd(fsps_pkg::OFF_STATUS, 16'h0000);
        // Slot A float LED setup, slot B two-pulse float setup firing the second LED
        wr(fsps_pkg::OFF_SRC_SEL, 16'h0004);
        wr(fsps_pkg::OFF_A_FECFG, 16'hae65);
        wr(fsps_pkg::OFF_A_AMPREF, 16'h0020);
        wr(fsps_pkg::OFF_CATHODE, 16'h0a00);
        wr(fsps_pkg::OFF_A_PULSE, 16'h0101);
        wr(fsps_pkg::OFF_A_CNTPER, 16'h0802);
        wr(fsps_pkg::OFF_A_INTEG, 16'h1000);
        wr(fsps_pkg::OFF_A_FLTCTL, 16'h6100);
        wr(fsps_pkg::OFF_MATH, 16'h0924);
        wr(fsps_pkg::OFF_FIRE, 16'h9600);
        wr(fsps_pkg::OFF_A_LEDSEL, 16'h4000);
        wr(fsps_pkg::OFF_B_LEDSEL, 16'h8000);
        wr(fsps_pkg::OFF_B_PULSE, 16'h0100);
        wr(fsps_pkg::OFF_B_CNTPER, 16'h0200);
        wr(fsps_pkg::OFF_B_FLTCTL, 16'h6000);
        wr(fsps_pkg::OFF_B_INTEG, 16'h1000);
        wr(fsps_pkg::OFF_PER_HI, 16'h0100);
        rd(fsps_pkg::OFF_PER_HI, 16'h0100);
        rd(fsps_pkg::OFF_FIRE, 16'h9600);
        // Slot B source not zero: start ignored
        @(posedge CLK) #1;
        SLOT_START = 1'b1;
        SLOT_IS_B = 1'b1;
        @(posedge CLK) #1;
        SLOT_START = 1'b0;
        repeat (4) @(posedge CLK);
        #1 chk("busy after refused start", 32'h0, {31'h0, BUSY});
        // Slot A: eight pulses, prompt converter, cathode from default input
        run(1'b0, 8000, w);
        chk("writes slot A", 32'd1, w);
        chk("result slot A", {12'h000, exp_sum(8, 4'b1001)}, {12'h000, DATA_OUT});
        chk("result slot tag A", 32'h0, {31'h0, DATA_SLOT});
        chk("float cycles A", 32'd1875, fsps_analog_model_i.float_cnt);
        chk("integ cycles A", 32'd2000, fsps_analog_model_i.integ_cnt);
        chk("cathode A", 32'h1, {30'h0, fsps_analog_model_i.cath_seen});
        for (int i = 0; i < 8; i++) begin
            chk($sformatf("LED pulse %0d", i), ((i % 4 == 1) || (i % 4 == 2)) ? 32'h1 : 32'h0,
                {29'h0, fsps_analog_model_i.led_seen[i]});
        end
        // Slot B: two pulses, long second float, slow converter, cathode override
        wr(fsps_pkg::OFF_SRC_SEL, 16'h0000);
        wr(fsps_pkg::OFF_CATHODE, 16'h0a80);
        adc_delay = 4'h7;
        run(1'b1, 40000, w);
        chk("writes slot B", 32'd1, w);
        chk("result slot B", {12'h000, exp_sum(2, 4'b0010)}, {12'h000, DATA_OUT});
        chk("result slot tag B", 32'h1, {31'h0, DATA_SLOT});
        chk("float cycles B", 32'd32125, fsps_analog_model_i.float_cnt);
        chk("integ cycles B", 32'd500, fsps_analog_model_i.integ_cnt);
        chk("cathode B", 32'h2, {30'h0, fsps_analog_model_i.cath_seen});
        chk("LED B first", 32'h2, {29'h0, fsps_analog_model_i.led_seen[0]});
        chk("LED B second", 32'h0, {29'h0, fsps_analog_model_i.led_seen[1]});
        end_sim();
    end
endmodule
